// ### core/plips_pkg.sv
// Constants and types shared by the link interface power sequencer.
package plips_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS        = 25000;
   localparam int RESET_DETECT_TIME_NS = 2600;
   localparam int DISABLE_DETECT_TIME_NS = 26030;
   localparam int CLK_ACTIVATE_TIME_NS = 60;
   localparam int LINK_PERIOD_PS       = 20345;
   // Least times round up, longest times round down.
   localparam int RESET_DETECT_CYC     = (RESET_DETECT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DISABLE_DETECT_CYC   = (DISABLE_DETECT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CLK_ACTIVATE_RAW     = (CLK_ACTIVATE_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int CLK_ACTIVATE_CYC     = (CLK_ACTIVATE_RAW < 1) ? 1 : CLK_ACTIVATE_RAW;
   localparam int LINK_HALF_RAW        = (LINK_PERIOD_PS / 2) / CLK_PERIOD_PS;
   localparam int LINK_HALF_CYC        = (LINK_HALF_RAW < 1) ? 1 : LINK_HALF_RAW;

   localparam int LOW_CNT_W            = 11;
   localparam logic [LOW_CNT_W-1:0] LOW_CNT_RST = LOW_CNT_W'(RESET_DETECT_CYC);
   localparam logic [LOW_CNT_W-1:0] LOW_CNT_DIS = LOW_CNT_W'(DISABLE_DETECT_CYC);

   // ----------------------------------------------------------------
   // Handshake cycle numbers and line codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CYC_ISO_LOW   = 4'h1;
   localparam logic [3:0] CYC_LAST_LOW  = 4'h7;
   localparam logic [3:0] CYC_RECV      = 4'h8;
   localparam logic [3:0] CYC_RECV_LAST = 4'h9;
   localparam logic [1:0] CTL_IDLE      = 2'h0;
   localparam logic [1:0] CTL_RECV      = 2'h1;
   localparam logic [7:0] DATA_ZERO     = 8'h00;
   localparam logic [7:0] DATA_ONES     = 8'hFF;
   localparam logic [2:0] HALF_CNT_W1   = 3'(LINK_HALF_CYC - 1);

   typedef enum logic [4:0] {
      ST_DIS  = 5'h01,
      ST_RST  = 5'h02,
      ST_INIT = 5'h04,
      ST_RECV = 5'h08,
      ST_NORM = 5'h10
   } plips_state_t;

endpackage : plips_pkg

// ### core/plips_clk_if.sv
// Interface between the sequencer and its link clock generator.
`timescale 1ns/100ps
`default_nettype none
interface plips_clk_if;
   logic run;
   logic level;
   logic rise;
   modport seq (output run, input level, input rise);
   modport gen (input run, output level, output rise);
endinterface : plips_clk_if
`default_nettype wire

// ### core/plips_clkgen.sv
// Link clock generator: starts low for half a period, then square wave.
`timescale 1ns/100ps
`default_nettype none
module plips_clkgen
(
   // Clock, reset, enable
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   // Sequencer side
   plips_clk_if.gen  cif
);
   typedef struct packed {
      logic [2:0] cnt;
      logic       level;
      logic       rise;
   } plips_gen_t;

   plips_gen_t st;
   plips_gen_t next_st;

   assign cif.level = st.level;
   assign cif.rise  = st.rise;

   // A stopped clock always restarts in its low phase, so the far end
   // sees a full low half period before the first rising edge.
   always_comb
   begin
      next_st      = st;
      next_st.rise = 1'b0;
      if (!cif.run)
      begin
         next_st.cnt   = 3'h0;
         next_st.level = 1'b0;
      end
      else if (st.cnt == plips_pkg::HALF_CNT_W1)
      begin
         next_st.cnt   = 3'h0;
         next_st.level = !st.level;
         next_st.rise  = !st.level;
      end
      else
      begin
         next_st.cnt = st.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else if (ce)
         st <= next_st;
   end

   clkLowStart_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
      $rose(cif.run) |-> !cif.level ##1 cif.level)
      else $error("Link clock did not start low.");

endmodule : plips_clkgen
`default_nettype wire

// ### core/plips_seq.sv
// Link interface power sequencer: reset, disable and initialization.
//
// Functional notes
// - Isolated reset: outputs end low then float.
// - Direct reset: drive control and data low.
// - Isolated disable: float the link clock.
// - Direct disable: hold link clock low.
// - Power status return reinitializes the interface.
// - Link clock restarts within 60 ns.
// - Link clock square wave, 49.152 MHz nominal; the generator toggles every local cycle, giving 20 MHz.
// - Isolated: clock starts with low half period.
// - Isolated: first full cycle drives lines low.
// - Direct: lines driven low first seven cycles.
// - Eighth cycle: receive code, data all ones.
// - Isolated: receive driven only first cycle.
// - Idle code ends init; requests accepted after.
// - Handshake also runs after reset-only.
// - Not operational: requests ignored, status discarded.
// - Hardware reset enters disabled state.
`timescale 1ns/100ps
`default_nettype none
module plips_seq
(
   // Clock, reset, enable
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   // Pins from the link layer controller
   input  wire logic       linkPowerStatus,
   input  wire logic       linkRequestLine,
   input  wire logic       isoMode,
   // Control and data lines
   output var  logic [1:0] controlLines,
   output var  logic       controlLinesOe_n,
   output var  logic [7:0] dataLines,
   output var  logic       dataLinesOe_n,
   // Link clock
   output var  logic       linkClockOutput,
   output var  logic       linkClockOutputOe_n,
   // Towards the packet logic
   output var  logic       linkRequestAccepted,
   output var  logic       ifaceOperational
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                               lps1;
      logic                               lps2;
      logic                               lreq1;
      logic                               lreq2;
      logic                               iso1;
      logic                               iso2;
      plips_pkg::plips_state_t            fsm;
      logic [plips_pkg::LOW_CNT_W-1:0]    lowCnt;
      logic [3:0]                         linkCyc;
      logic                               run;
      logic [1:0]                         ctl;
      logic                               ctlOe_n;
      logic [7:0]                         data;
      logic                               dataOe_n;
      logic                               clkOe_n;
      logic                               lreqPass;
      logic                               up;
   } plips_seq_t;

   localparam int ActMax = plips_pkg::CLK_ACTIVATE_CYC;

   plips_seq_t  st;
   plips_seq_t  next_st;
   plips_clk_if cif ();

   plips_clkgen u_clkgen
   (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .cif  (cif.gen)
   );

   // The generator sees the stop one cycle early, so the link clock is
   // already low on the edge that enters the disabled state.
   assign cif.run             = st.run && next_st.run;
   assign controlLines        = st.ctl;
   assign controlLinesOe_n    = st.ctlOe_n;
   assign dataLines           = st.data;
   assign dataLinesOe_n       = st.dataOe_n;
   assign linkClockOutput     = cif.level;
   assign linkClockOutputOe_n = st.clkOe_n;
   assign linkRequestAccepted = st.lreqPass;
   assign ifaceOperational    = st.up;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // The low time is counted on the local clock because the link clock
   // is stopped while the interface is disabled. A pulsed power status
   // restarts the count on every high phase.
   always_comb
   begin
      next_st          = st;
      next_st.lps1     = linkPowerStatus;
      next_st.lps2     = st.lps1;
      next_st.lreq1    = linkRequestLine;
      next_st.lreq2    = st.lreq1;
      next_st.iso1     = isoMode;
      next_st.iso2     = st.iso1;
      next_st.lreqPass = 1'b0;
      if (st.lps2)
         next_st.lowCnt = '0;
      else if (st.lowCnt != plips_pkg::LOW_CNT_DIS)
         next_st.lowCnt = st.lowCnt + 11'h001;

      case (st.fsm)
         plips_pkg::ST_DIS:
         begin
            if (st.lps2)
            begin
               next_st.fsm     = plips_pkg::ST_INIT;
               next_st.linkCyc = 4'h0;
            end
         end
         plips_pkg::ST_RST:
         begin
            if (!st.lps2 && st.lowCnt >= plips_pkg::LOW_CNT_DIS - 11'h001)
               next_st.fsm = plips_pkg::ST_DIS;
            else if (st.lps2)
            begin
               next_st.fsm     = plips_pkg::ST_INIT;
               next_st.linkCyc = 4'h0;
            end
         end
         plips_pkg::ST_INIT,
         plips_pkg::ST_RECV,
         plips_pkg::ST_NORM:
         begin
            if (!st.lps2 && st.lowCnt >= plips_pkg::LOW_CNT_RST - 11'h001)
               next_st.fsm = plips_pkg::ST_RST;
            else if (st.fsm == plips_pkg::ST_NORM)
               next_st.lreqPass = st.lreq2;
            else if (cif.rise)
            begin
               next_st.linkCyc = st.linkCyc + 4'h1;
               if (st.fsm == plips_pkg::ST_INIT && st.linkCyc == plips_pkg::CYC_LAST_LOW)
                  next_st.fsm = plips_pkg::ST_RECV;
               else if (st.fsm == plips_pkg::ST_RECV && st.linkCyc == plips_pkg::CYC_RECV_LAST)
                  next_st.fsm = plips_pkg::ST_NORM;
            end
         end
         default:
            next_st.fsm = plips_pkg::ST_DIS;
      endcase

      // Outputs follow the next state so that they change with it.
      next_st.run      = (next_st.fsm != plips_pkg::ST_DIS);
      next_st.up       = (next_st.fsm == plips_pkg::ST_NORM);
      next_st.clkOe_n  = (next_st.fsm == plips_pkg::ST_DIS) && !next_st.iso2;
      next_st.ctl      = plips_pkg::CTL_IDLE;
      next_st.data     = plips_pkg::DATA_ZERO;
      next_st.ctlOe_n  = 1'b0;
      case (next_st.fsm)
         plips_pkg::ST_DIS,
         plips_pkg::ST_RST:
            next_st.ctlOe_n = !next_st.iso2;
         plips_pkg::ST_INIT:
            next_st.ctlOe_n = !next_st.iso2 && (next_st.linkCyc != plips_pkg::CYC_ISO_LOW);
         plips_pkg::ST_RECV:
         begin
            next_st.ctl     = plips_pkg::CTL_RECV;
            next_st.data    = plips_pkg::DATA_ONES;
            next_st.ctlOe_n = !next_st.iso2 && (next_st.linkCyc != plips_pkg::CYC_RECV);
         end
         plips_pkg::ST_NORM:
            next_st.ctlOe_n = 1'b0;
         default:
            next_st.ctlOe_n = 1'b1;
      endcase
      next_st.dataOe_n = next_st.ctlOe_n;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Hardware reset leaves the interface disabled with outputs floated.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st          <= '0;
         st.fsm      <= plips_pkg::ST_DIS;
         st.ctlOe_n  <= 1'b1;
         st.dataOe_n <= 1'b1;
         st.clkOe_n  <= 1'b1;
      end
      else if (ce)
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   rstFloat_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_RST && !st.iso2 |-> st.ctlOe_n && st.dataOe_n && st.ctl == 2'h0 && st.data == 8'h00)
      else $error("Isolated reset lines not floated low.");
   rstDrive_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_RST && st.iso2 |-> !st.ctlOe_n && !st.dataOe_n && st.data == 8'h00)
      else $error("Direct reset lines not driven low.");
   resetEntry_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && st.fsm == plips_pkg::ST_NORM && !st.lps2 && st.lowCnt == plips_pkg::LOW_CNT_RST - 11'h001
      |=> st.fsm == plips_pkg::ST_RST)
      else $error("Reset not entered after detection time.");
   disClock_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_DIS |-> (st.clkOe_n == !st.iso2) && !cif.level)
      else $error("Disabled link clock in wrong state.");
   clkRestart_a: assert property (@(posedge clk) disable iff (!nrst || !ce)
      st.fsm == plips_pkg::ST_DIS && st.lps2 |-> ##[1:ActMax] !st.clkOe_n && st.run)
      else $error("Link clock not restarted in time.");
   isoFirstLow_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_INIT && !st.iso2 |-> st.ctlOe_n == (st.linkCyc != 4'h1))
      else $error("Isolated init low cycle wrong.");
   directLow_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_INIT && st.iso2 |-> !st.ctlOe_n && st.ctl == 2'h0 && st.data == 8'h00)
      else $error("Direct init lines not held low.");
   recvCode_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(st.fsm == plips_pkg::ST_RECV) |-> st.linkCyc == 4'h8 && st.ctl == 2'h1 && st.data == 8'hFF
      && !st.ctlOe_n)
      else $error("Receive code wrong on eighth cycle.");
   recvFloat_a: assert property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_RECV && !st.iso2 && st.linkCyc == 4'h9 |-> st.ctlOe_n && st.dataOe_n)
      else $error("Isolated receive not floated.");
   reqGate_a: assert property (@(posedge clk) disable iff (!nrst)
      st.lreqPass |-> $past(st.fsm) == plips_pkg::ST_NORM && st.up)
      else $error("Request passed while not operational.");

   initDone_c:  cover property (@(posedge clk) disable iff (!nrst) $rose(st.fsm == plips_pkg::ST_NORM));
   disabled_c:  cover property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_RST ##1 st.fsm == plips_pkg::ST_DIS);
   resetOnly_c: cover property (@(posedge clk) disable iff (!nrst)
      st.fsm == plips_pkg::ST_RST ##1 st.fsm == plips_pkg::ST_INIT);

endmodule : plips_seq
`default_nettype wire

// ### verif/plips_llc_model.sv
// Behavioural link layer controller model for the power sequencer bench.
`timescale 1ns/100ps
`default_nettype none
module plips_llc_model
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Bench commands
   input  wire logic wantPower,
   input  wire logic wantRequest,
   // Pins towards the sequencer
   output var  logic linkPowerStatus,
   output wire logic linkRequestLine
);
   // ---------------------------------------------------------------
   // Power status with restore wait
   // ---------------------------------------------------------------
   int offCnt;
   int onCnt;
   // A short drop never reached reset, so power may come straight back.
   // Otherwise the restore time counts from reset entry, which comes
   // about 106 cycles after the pin falls.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         offCnt <= 0;
         onCnt <= 0;
         linkPowerStatus <= 1'b0;
      end
      else if (wantPower && (offCnt < 100 || offCnt >= 710))
      begin
         offCnt <= 0;
         if (onCnt < 8)
            onCnt <= onCnt + 1;
         linkPowerStatus <= 1'b1;
      end
      else
      begin
         offCnt <= offCnt + 1;
         onCnt <= 0;
         linkPowerStatus <= 1'b0;
      end
   end
   // The request stays low whenever power status is low, and for seven
   // cycles after it rises, which covers the first link clock cycles.
   assign linkRequestLine = wantRequest & linkPowerStatus & (onCnt >= 8);
endmodule : plips_llc_model
`default_nettype wire

// ### verif/plips_seq_test.sv
// Self-checking bench for the link interface power sequencer.
`timescale 1ns/100ps
`default_nettype none
module plips_seq_test;
   typedef struct {string nm; logic [15:0] exp; logic [15:0] got;} plips_note_t;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        ce = 1'b1;
   logic        isoMode = 1'b0;
   logic        wantPower = 1'b0;
   logic        wantRequest = 1'b0;
   logic        linkPowerStatus;
   logic        linkRequestLine;
   logic [1:0]  controlLines;
   logic        controlLinesOe_n;
   logic [7:0]  dataLines;
   logic        dataLinesOe_n;
   logic        linkClockOutput;
   logic        linkClockOutputOe_n;
   logic        linkRequestAccepted;
   logic        ifaceOperational;
   logic [7:0]  lfsr = 8'h59;
   logic [1:0]  frozen;
   int          fails = 0;
   int          n_compared = 0;
   int          cyc = 0;
   plips_note_t notes[$];

   always #12.5 clk = ~clk;

   plips_seq plips_seq_inst (.clk, .nrst, .ce, .linkPowerStatus, .linkRequestLine, .isoMode, .controlLines,
      .controlLinesOe_n, .dataLines, .dataLinesOe_n, .linkClockOutput, .linkClockOutputOe_n,
      .linkRequestAccepted, .ifaceOperational);
   plips_llc_model plips_llc_model_inst (.clk, .nrst, .wantPower, .wantRequest, .linkPowerStatus,
      .linkRequestLine);

   // ---------------------------------------------------------------
   // Notes, comparison and verdict
   // ---------------------------------------------------------------
   function automatic logic [7:0] nextRand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nextRand

   task automatic note(input string nm, input logic [15:0] exp, input logic [15:0] got);
      notes.push_back('{nm, exp, got});
   endtask : note

   task automatic check(input plips_note_t n);
      n_compared++;
      if (n.got !== n.exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n.nm, n.exp, n.got);
      end
   endtask : check

   task automatic end_of_test;
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // Results are judged on the falling clock edge on which the driver noted them, or one cycle later.
   always @(negedge clk)
      while (notes.size() > 0)
         check(notes.pop_front());

   // The whole run needs about 5300 cycles.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         fails++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   task automatic hwReset(input logic iso);
      logic moved;
      moved = 1'b0;
      wantPower = 1'b0;
      wantRequest = 1'b0;
      isoMode = iso;
      nrst = 1'b0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      note("operational", 16'h0, ifaceOperational);
      note("clock oe", !iso, linkClockOutputOe_n);
      note("control oe", !iso, controlLinesOe_n);
      repeat (600)
      begin
         @(negedge clk);
         if (linkClockOutput !== 1'b0)
            moved = 1'b1;
      end
      note("clock stopped", 16'h0, moved);
   endtask : hwReset

   task automatic powerUp(input logic fromDis);
      int   lat;
      int   rises;
      int   lowCyc;
      int   recvCyc;
      logic flt;
      logic clkOff;
      logic leak;
      logic lowFirst;
      logic prevClk;
      lat = 0;
      rises = 0;
      lowCyc = 0;
      recvCyc = 0;
      flt = 1'b0;
      clkOff = 1'b0;
      leak = 1'b0;
      lowFirst = 1'b0;
      prevClk = linkClockOutput;
      wantRequest = !isoMode;
      wantPower = 1'b1;
      for (int i = 1; i < 200 && ifaceOperational !== 1'b1; i++)
      begin
         @(negedge clk);
         if (linkClockOutput === 1'b1 && prevClk === 1'b0 && recvCyc == 0)
            rises++;
         if (rises == 0 && linkClockOutputOe_n === 1'b0 && linkClockOutput === 1'b0)
            lowFirst = 1'b1;
         if (rises == 0 && linkPowerStatus === 1'b1)
            lat++;
         if (controlLinesOe_n === 1'b0 && controlLines === 2'h1 && dataLines === 8'hFF)
            recvCyc++;
         else if (recvCyc == 0 && rises > 0 && controlLinesOe_n === 1'b0 && {controlLines, dataLines} === 10'h0)
            lowCyc++;
         if (recvCyc == 0 && rises > 0 && controlLinesOe_n !== 1'b0)
            flt = 1'b1;
         if (linkClockOutputOe_n !== 1'b0)
            clkOff = 1'b1;
         if (ifaceOperational !== 1'b1 && linkRequestAccepted !== 1'b0)
            leak = 1'b1;
         prevClk = linkClockOutput;
      end
      note("operational", 16'h1, ifaceOperational);
      note("idle lines", 16'h0, {controlLinesOe_n, controlLines, dataLines});
      note("data oe", 16'h0, dataLinesOe_n);
      note("request ignored", 16'h0, leak);
      note("floated in init", !isoMode, flt);
      note("receive cycles", isoMode ? 16'h4 : 16'h2, recvCyc);
      if (!isoMode)
         note("low cycles", 16'h2, lowCyc);
      if (fromDis)
      begin
         note("restart delay", 16'h1, lat > 0 && lat <= 5);
         note("first half low", 16'h1, lowFirst);
         note("rises to receive", 16'h8, rises);
      end
      else
         note("clock kept", 16'h0, clkOff);
   endtask : powerUp

   task automatic powerDown(input int n);
      wantPower = 1'b0;
      repeat (n) @(negedge clk);
   endtask : powerDown

   initial
   begin
      hwReset(1'b0);
      powerUp(1'b1);
      repeat (12)
      begin
         lfsr = nextRand(lfsr);
         wantRequest = lfsr[0];
         repeat (4) @(negedge clk);
         note("request", lfsr[0], linkRequestAccepted);
      end
      ce = 1'b0;
      frozen = {linkClockOutput, linkRequestAccepted};
      wantRequest = !wantRequest;
      repeat (6) @(negedge clk);
      note("frozen", frozen, {linkClockOutput, linkRequestAccepted});
      ce = 1'b1;
      powerDown(80);
      note("short drop", 16'h1, ifaceOperational);
      wantPower = 1'b1;
      repeat (5) @(negedge clk);
      powerDown(650);
      note("reset state", 16'h2, {ifaceOperational, controlLinesOe_n, linkClockOutputOe_n});
      note("accepted off", 16'h0, linkRequestAccepted);
      powerUp(1'b0);
      powerDown(1100);
      note("disabled clock oe", 16'h1, linkClockOutputOe_n);
      powerUp(1'b1);
      hwReset(1'b1);
      powerUp(1'b1);
      powerDown(650);
      note("direct reset", 16'h0, {controlLinesOe_n, dataLinesOe_n, controlLines, dataLines});
      powerUp(1'b0);
      powerDown(1100);
      note("direct disable", 16'h0, {linkClockOutputOe_n, linkClockOutput});
      repeat (2) @(negedge clk);
      end_of_test();
   end
endmodule : plips_seq_test
`default_nettype wire
